// *** logic/bsl_axi_slave.sv ***
// axi4-lite slave front end: one write and one read in flight at most
// assumes a master that holds valid and payload until ready, per the bus spec
`timescale 1ns/1ps
module bsl_axi_slave
  import bsl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  bsl_reg_if.slave bus
);
  typedef struct packed {
    logic aw_have; logic w_have; logic [7:0] aw_addr; logic [31:0] w_data;
    logic [3:0] w_strb; logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } bsl_axi_t;
  bsl_axi_t q, d;

  assign bus.wr_addr = q.aw_addr;
  assign bus.wr_data = q.w_data;
  assign bus.wr_strb = q.w_strb;
  assign bus.wr_en = q.aw_have && q.w_have && !q.bvalid; // commit once both halves are held
  assign bus.rd_addr = araddr;

  // channel bookkeeping; readies are registered so outputs come from flops
  always_comb begin
    d = q;
    if (awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.aw_addr = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.w_data = wdata;
      d.w_strb = wstrb;
    end
    if (bus.wr_en) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = bus.wr_hit ? BSL_RESP_OKAY : BSL_RESP_SLVERR;
    end else if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rdata = bus.rd_hit ? bus.rd_data : 32'h0000_0000;
      d.rresp = bus.rd_hit ? BSL_RESP_OKAY : BSL_RESP_SLVERR;
    end else if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    d.awready = !d.aw_have && !d.bvalid;
    d.wready = !d.w_have && !d.bvalid;
    d.arready = !d.rvalid;
  end

  // state register, synchronous reset
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
endmodule // bsl_axi_slave

// *** logic/bsl_cond.sv ***
// status flag test for the relative branches
// assumes flags are laid out i,t,h,s,v,n,z,c from bit 7 down
`timescale 1ns/1ps
module bsl_cond
  import bsl_pkg::*;
(
  input wire logic [7:0] flags,
  input wire logic [2:0] sel,
  input wire logic want_set,
  output logic take
);
  logic bit_v; // selected condition value

  // signed selector looks at n xor v directly, so a stale s bit cannot mislead it
  always_comb begin
    if (sel == BSL_SEL_SIGNED) begin
      bit_v = flags[BSL_FLAG_N] ^ flags[BSL_FLAG_V];
    end else begin
      bit_v = flags[sel];
    end
    take = (bit_v == want_set);
  end
endmodule // bsl_cond

// *** logic/bsl_exec_top.sv ***
// What this block does
// - equal registers skip next instruction, flags kept
// - register bit clear skips next instruction
// - register bit set skips next instruction
// - i/o bit clear skips, two to four cycles
// - i/o bit set skips, two to four cycles
// - flag-set branch jumps pc plus k plus one
// - flag-clear branch jumps when flag zero
// - carry clear/same-or-higher on c zero, else set
// - signed greater-or-equal when n xor v zero
// - signed less-than when n xor v one
// - half-carry branches follow h flag
// - transfer-bit branches follow t flag
// - overflow branches follow v flag
// - interrupts-enabled branch on i one, i kept
// - interrupts-disabled branch on i zero
// - direct load reads address word, two cycles
// - pre-decrement pointer, then load, two cycles
// - load at pointer, then increment, one cycle
//
// execution core for skips, relative branches and data-space loads
// assumes a data-space memory that answers ds_rdata in the same cycle as ds_rd
`timescale 1ns/1ps
module bsl_exec_top
  import bsl_pkg::*;
#(
  parameter int PC_W = 16 // program counter width in bits
)(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [15:0] ds_addr,
  output logic ds_rd,
  input wire logic [7:0] ds_rdata,
  output logic exec_busy
);

  ////////////////////////////////////////////////////////////////////////////////
  // elaboration checks

  if (PC_W < 8 || PC_W > 16) begin : g_bad_pc_w
    $error("bsl_exec_top: PC_W must lie in 8..16");
  end

  localparam logic [15:0] PC_MASK = 16'((32'h1 << PC_W) - 32'h1); // wrap of the pc

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    bsl_state_t st; // sequencer
    bsl_op_t op; // class of the running instruction
    logic [15:0] instr; // first instruction word
    logic [15:0] word2; // address word of a direct load
    logic next_long; // following instruction is two words
    logic [15:0] pc; // program counter, word address
    logic [7:0] flags; // flag_register image
    logic [4:0] regsel; // register file index for software access
    logic [31:0][7:0] rf; // general purpose registers
    logic [2:0] left; // hold cycles still to run
    logic [2:0] last_cyc; // cycles used by the last instruction
    logic illegal; // last word was not one of ours
    logic done; // sticky completion flag
    logic ds_rd; // data space read strobe
    logic [15:0] ds_addr; // data space address
    logic busy; // execution in progress
  } bsl_core_t;

  bsl_core_t q, d;

  bsl_reg_if bus ();

  logic br_take; // branch condition from the flag tester

  ////////////////////////////////////////////////////////////////////////////////
  // submodules

  // bus front end
  bsl_axi_slave u_axi (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .bus(bus)
  );

  // flag tester; bit 10 low selects the flag-set form
  bsl_cond u_cond (
    .flags(q.flags),
    .sel(q.instr[2:0]),
    .want_set(!q.instr[10]),
    .take(br_take)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register map decode and read mux

  always_comb begin
    bus.wr_hit = (bus.wr_addr[1:0] == 2'b00) && (bus.wr_addr <= BSL_OFF_REGDATA);
    bus.rd_hit = (bus.rd_addr[1:0] == 2'b00) && (bus.rd_addr <= BSL_OFF_REGDATA);
    case (bus.rd_addr)
      BSL_OFF_CTRL: bus.rd_data = 32'h0000_0000; // start is write-only
      BSL_OFF_INSTR: bus.rd_data = {q.word2, q.instr};
      BSL_OFF_NEXT: bus.rd_data = {31'h0000_0000, q.next_long};
      BSL_OFF_PC: bus.rd_data = {16'h0000, q.pc};
      BSL_OFF_FLAGS: bus.rd_data = {24'h00_0000, q.flags};
      BSL_OFF_STATUS: begin
        bus.rd_data = 32'h0000_0000;
        bus.rd_data[BSL_STAT_BUSY] = q.busy;
        bus.rd_data[BSL_STAT_ILLEGAL] = q.illegal;
        bus.rd_data[BSL_STAT_DONE] = q.done;
        bus.rd_data[BSL_STAT_CYC_LO +: 3] = q.last_cyc;
      end
      BSL_OFF_REGSEL: bus.rd_data = {27'h000_0000, q.regsel};
      BSL_OFF_REGDATA: bus.rd_data = {24'h00_0000, q.rf[q.regsel]};
      default: bus.rd_data = 32'h0000_0000; // unmapped reads as zero
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic start; // software asked for one instruction
    logic cond; // skip or branch condition
    logic [2:0] cyc; // total cycles of this instruction
    logic [4:0] pidx; // pointer pair low index
    logic [15:0] ptr; // pointer pair value
    logic [31:0] mw; // merged write word
    logic [15:0] pc1; // address of the following instruction
    bsl_op_t kind; // decoded class at start
    start = 1'b0;
    cond = 1'b0;
    cyc = BSL_CYC_ONE;
    pidx = BSL_PTR_X;
    ptr = 16'h0000;
    mw = 32'h0000_0000;
    pc1 = (q.pc + 16'h0001) & PC_MASK;
    kind = bsl_decode(q.instr);
    d = q;
    d.ds_rd = 1'b0;

    // pointer pair picked by bits 3:2 of the load word
    case (q.instr[3:2])
      2'b11: pidx = BSL_PTR_X;
      2'b10: pidx = BSL_PTR_Y;
      default: pidx = BSL_PTR_Z;
    endcase
    ptr = {q.rf[pidx + 5'h01], q.rf[pidx]};

    // software writes; core state is frozen while an instruction runs,
    // so a write then, other than to regsel or status, is answered but dropped rather than racing the core
    if (bus.wr_en && bus.wr_hit) begin
      mw = 32'h0000_0000;
      case (bus.wr_addr)
        BSL_OFF_CTRL: start = bus.wr_strb[0] && bus.wr_data[BSL_CTRL_START] && !q.busy;
        BSL_OFF_INSTR: begin
          mw = bsl_merge({q.word2, q.instr}, bus.wr_data, bus.wr_strb);
          if (!q.busy) begin
            d.instr = mw[15:0];
            d.word2 = mw[31:16];
          end
        end
        BSL_OFF_NEXT: if (!q.busy && bus.wr_strb[0]) d.next_long = bus.wr_data[0];
        BSL_OFF_PC: begin
          mw = bsl_merge({16'h0000, q.pc}, bus.wr_data, bus.wr_strb);
          if (!q.busy) d.pc = mw[15:0] & PC_MASK;
        end
        BSL_OFF_FLAGS: if (!q.busy && bus.wr_strb[0]) d.flags = bus.wr_data[7:0];
        BSL_OFF_STATUS: begin
          // write one clears done; completion in the same cycle wins below
          if (bus.wr_strb[0] && bus.wr_data[BSL_STAT_DONE]) d.done = 1'b0;
        end
        BSL_OFF_REGSEL: if (bus.wr_strb[0]) d.regsel = bus.wr_data[4:0];
        BSL_OFF_REGDATA: if (!q.busy && bus.wr_strb[0]) d.rf[q.regsel] = bus.wr_data[7:0];
        default: d.regsel = q.regsel; // nothing else is writable
      endcase
    end

    case (q.st)
      // idle: latch the class and issue any data read for the next cycle
      BSL_IDLE: begin
        if (start) begin
          d.op = kind;
          d.st = BSL_EXEC;
          d.busy = 1'b1;
          if (kind == BSL_OP_IO_SKIP) begin
            d.ds_rd = 1'b1;
            d.ds_addr = BSL_IO_BASE + {11'h000, q.instr[7:3]};
          end else if (kind == BSL_OP_LOAD_DIRECT) begin
            d.ds_rd = 1'b1;
            d.ds_addr = q.word2;
          end else if (kind == BSL_OP_LOAD_IND) begin
            d.ds_rd = 1'b1;
            if (q.instr[1:0] == 2'b10) begin
              d.ds_addr = ptr - 16'h0001;
            end else begin
              d.ds_addr = ptr;
            end
          end
        end
      end
      // exec: data has arrived, decide, write back and set the pc
      BSL_EXEC: begin
        // flags are never written here, only read
        d.illegal = 1'b0;
        case (q.op)
          BSL_OP_CMP_SKIP: cond = q.rf[q.instr[8:4]] == q.rf[{q.instr[9], q.instr[3:0]}];
          BSL_OP_REG_SKIP: cond = q.rf[q.instr[8:4]][q.instr[2:0]] == q.instr[9];
          BSL_OP_IO_SKIP: cond = ds_rdata[q.instr[2:0]] == q.instr[9];
          BSL_OP_BRANCH: cond = br_take;
          default: cond = 1'b0;
        endcase
        case (q.op)
          BSL_OP_CMP_SKIP, BSL_OP_REG_SKIP, BSL_OP_IO_SKIP: begin
            // io skips pay one cycle more for the i/o read
            cyc = (q.op == BSL_OP_IO_SKIP) ? BSL_CYC_TWO : BSL_CYC_ONE;
            if (cond) begin
              d.pc = (q.pc + (q.next_long ? 16'h0003 : 16'h0002)) & PC_MASK;
              cyc = cyc + (q.next_long ? 3'h2 : 3'h1);
            end else begin
              d.pc = pc1;
            end
          end
          BSL_OP_BRANCH: begin
            if (cond) begin
              d.pc = (q.pc + {{9{q.instr[9]}}, q.instr[9:3]} + 16'h0001) & PC_MASK;
              cyc = BSL_CYC_TWO;
            end else begin
              d.pc = pc1;
              cyc = BSL_CYC_ONE;
            end
          end
          BSL_OP_LOAD_DIRECT: begin
            d.rf[q.instr[8:4]] = ds_rdata;
            d.pc = (q.pc + 16'h0002) & PC_MASK; // two-word instruction
            cyc = BSL_CYC_TWO;
          end
          BSL_OP_LOAD_IND: begin
            // pointer first so a load into its own pointer keeps the data
            if (q.instr[1:0] == 2'b10) begin
              {d.rf[pidx + 5'h01], d.rf[pidx]} = ptr - 16'h0001;
              cyc = BSL_CYC_TWO;
            end else if (q.instr[1:0] == 2'b01) begin
              {d.rf[pidx + 5'h01], d.rf[pidx]} = ptr + 16'h0001;
              cyc = BSL_CYC_ONE;
            end else begin
              cyc = BSL_CYC_ONE;
            end
            d.rf[q.instr[8:4]] = ds_rdata;
            d.pc = pc1;
          end
          default: begin
            // unknown word: step over it and report
            d.illegal = 1'b1;
            d.pc = pc1;
            cyc = BSL_CYC_ONE;
          end
        endcase
        d.last_cyc = cyc;
        d.left = cyc - 3'h1;
        if (cyc == BSL_CYC_ONE) begin
          d.st = BSL_IDLE;
          d.busy = 1'b0;
          d.done = 1'b1;
        end else begin
          d.st = BSL_HOLD;
        end
      end
      // hold: burn the remaining cycles of a multi-cycle instruction
      BSL_HOLD: begin
        d.left = q.left - 3'h1;
        if (q.left == 3'h1) begin
          d.st = BSL_IDLE;
          d.busy = 1'b0;
          d.done = 1'b1;
        end
      end
      default: begin
        d.st = BSL_IDLE;
        d.busy = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register, synchronous reset

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q <= '0;
      q.st <= BSL_IDLE;
      q.op <= BSL_OP_ILLEGAL;
      q.pc <= BSL_PC_RST;
      q.flags <= BSL_FLAGS_RST;
    end else begin
      q <= d;
    end
  end

  assign ds_addr = q.ds_addr;
  assign ds_rd = q.ds_rd;
  assign exec_busy = q.busy;

endmodule // bsl_exec_top

// *** logic/bsl_pkg.sv ***
// shared constants, types and helpers for the branch/skip/load execution block
// assumes a single 20 MHz core clock and an AXI4-Lite master on the register side
package bsl_pkg;

  // register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] BSL_OFF_CTRL = 8'h00;
  localparam logic [7:0] BSL_OFF_INSTR = 8'h04;
  localparam logic [7:0] BSL_OFF_NEXT = 8'h08;
  localparam logic [7:0] BSL_OFF_PC = 8'h0C;
  localparam logic [7:0] BSL_OFF_FLAGS = 8'h10;
  localparam logic [7:0] BSL_OFF_STATUS = 8'h14;
  localparam logic [7:0] BSL_OFF_REGSEL = 8'h18;
  localparam logic [7:0] BSL_OFF_REGDATA = 8'h1C;

  // field positions
  localparam int BSL_CTRL_START = 0;
  localparam int BSL_STAT_BUSY = 0;
  localparam int BSL_STAT_ILLEGAL = 1;
  localparam int BSL_STAT_DONE = 2;
  localparam int BSL_STAT_CYC_LO = 4;
  localparam int BSL_FLAG_V = 3;
  localparam int BSL_FLAG_N = 2;
  localparam logic [2:0] BSL_SEL_SIGNED = 3'h4;

  // values after reset
  localparam logic [15:0] BSL_PC_RST = 16'h0000;
  localparam logic [7:0] BSL_FLAGS_RST = 8'h00;

  // pointer pair low register indices and i/o window base
  localparam logic [4:0] BSL_PTR_X = 5'h1A;
  localparam logic [4:0] BSL_PTR_Y = 5'h1C;
  localparam logic [4:0] BSL_PTR_Z = 5'h1E;
  localparam logic [15:0] BSL_IO_BASE = 16'h0000;

  // cycle counts
  localparam logic [2:0] BSL_CYC_ONE = 3'h1;
  localparam logic [2:0] BSL_CYC_TWO = 3'h2;

  // axi responses
  localparam logic [1:0] BSL_RESP_OKAY = 2'h0;
  localparam logic [1:0] BSL_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    BSL_IDLE = 3'b001,
    BSL_EXEC = 3'b010,
    BSL_HOLD = 3'b100
  } bsl_state_t;

  typedef enum logic [2:0] {
    BSL_OP_CMP_SKIP, BSL_OP_REG_SKIP, BSL_OP_IO_SKIP, BSL_OP_BRANCH,
    BSL_OP_LOAD_DIRECT, BSL_OP_LOAD_IND, BSL_OP_ILLEGAL
  } bsl_op_t;

  // instruction word classifier
  function automatic bsl_op_t bsl_decode(input logic [15:0] w);
    bsl_op_t k;
    k = BSL_OP_ILLEGAL;
    if (w[15:10] == 6'b000100) k = BSL_OP_CMP_SKIP;
    else if (w[15:10] == 6'b111111) begin
      // the 111110 row holds bit-transfer words, which must never skip
      if (!w[3]) k = BSL_OP_REG_SKIP;
    end
    else if (w[15:8] == 8'h99 || w[15:8] == 8'h9B) k = BSL_OP_IO_SKIP;
    else if (w[15:11] == 5'b11110) k = BSL_OP_BRANCH;
    else if (w[15:9] == 7'b1001000) begin
      if (w[3:0] == 4'h0) k = BSL_OP_LOAD_DIRECT;
      else if (w[3:0] inside {4'hC, 4'hD, 4'hE, 4'h9, 4'hA, 4'h1, 4'h2}) k = BSL_OP_LOAD_IND;
    end
    return k;
  endfunction

  // byte-lane merge of a write into an old word
  function automatic logic [31:0] bsl_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

endpackage

// *** logic/bsl_reg_if.sv ***
// register access carrier between the axi slave and the execution core
// assumes both ends sit on ref_clk; wr_en is a one-cycle strobe
`timescale 1ns/1ps
interface bsl_reg_if;
  logic wr_en; // write strobe
  logic [7:0] wr_addr; // write byte address
  logic [31:0] wr_data; // write data
  logic [3:0] wr_strb; // byte lanes
  logic wr_hit; // write address is mapped
  logic [7:0] rd_addr; // read byte address
  logic [31:0] rd_data; // read data, combinational
  logic rd_hit; // read address is mapped
  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                 input wr_hit, rd_data, rd_hit);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr,
                output wr_hit, rd_data, rd_hit);
endinterface

// *** testbench/bsl_monitor.sv ***
// checker for the execution handshake and the axi holds of bsl_exec_top
// assumes one clock, ref_clk, and nrst synchronous active low
`timescale 1ns/1ps
module bsl_monitor (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic ds_rd,
  input wire logic exec_busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // an instruction starts where busy rises
  sequence start_s;
    $rose(exec_busy);
  endsequence
  // a read is taken where address valid meets ready
  sequence rd_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  ds_pulse_a: assert property (ds_rd |=> !ds_rd)
    else $error("data read strobe longer than one cycle");
  ds_start_a: assert property (ds_rd |-> start_s)
    else $error("data read outside first busy cycle");
  busy_max_a: assert property (start_s |-> ##[1:4] !exec_busy)
    else $error("instruction longer than four cycles");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  r_answer_a: assert property (rd_take_s |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer not one cycle after address");
  w_answer_a: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:8] s_axi_bvalid)
    else $error("write answer missing");
  r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted while answer pending");
endmodule // bsl_monitor

bind bsl_exec_top bsl_monitor i_bsl_monitor (.ref_clk, .nrst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .ds_rd, .exec_busy);

// *** testbench/cpu_branch_skip_load_exec_bench.sv ***
// self-checking bench: drives bsl_exec_top through its axi4-lite slave
// assumes a combinational data space, modelled as a pattern of the address
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED at %0t got %h exp %h", $time, g, e); end end
module cpu_branch_skip_load_exec_bench import bsl_pkg::*;;
  logic ref_clk = 0, nrst = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, ds_rdata;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb = 4'hF; // full words only
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, ds_rd, exec_busy;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
  logic [15:0] ds_addr;
  int fail_count = 0, comparisons = 0;
  // data space content; idle bus shows the inverse so stale reads fail
  function automatic logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  assign ds_rdata = ds_rd ? mem(ds_addr) : ~mem(ds_addr);
  bsl_exec_top i_bsl_exec_top (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ds_addr, .ds_rd, .ds_rdata, .exec_busy);
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one write, both halves offered together, each released when taken
  // stall > 0 keeps bready low for that many edges of a pending response
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int stall = 0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (stall == 0);
    forever begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        resp_q = s_axi_bresp;
        break;
      end
      if (s_axi_bvalid) stall--;
      if (s_axi_bvalid && stall == 0) s_axi_bready <= 1'b1;
    end
  endtask
  // one read; data taken at the edge where rvalid meets rready
  task automatic rd(input logic [7:0] a, input int stall = 0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (stall == 0);
    forever begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        rd_q = s_axi_rdata;
        resp_q = s_axi_rresp;
        break;
      end
      if (s_axi_rvalid) stall--;
      if (s_axi_rvalid && stall == 0) s_axi_rready <= 1'b1;
    end
  endtask
  task automatic setreg(input logic [4:0] r, input logic [7:0] v);
    wr(BSL_OFF_REGSEL, {27'h0, r});
    wr(BSL_OFF_REGDATA, {24'h0, v});
  endtask
  task automatic getreg(input logic [4:0] r);
    wr(BSL_OFF_REGSEL, {27'h0, r});
    rd(BSL_OFF_REGDATA);
  endtask
  // run one instruction from pc 0x10, then check cycles, pc and flags
  task automatic run(input logic [31:0] ins, input logic [7:0] flg, input logic nx,
                     input logic [15:0] pc_e, input logic [2:0] cyc_e);
    wr(BSL_OFF_PC, 32'h10);
    wr(BSL_OFF_FLAGS, {24'h0, flg});
    wr(BSL_OFF_NEXT, {31'h0, nx});
    wr(BSL_OFF_INSTR, ins);
    wr(BSL_OFF_STATUS, 32'h4);
    wr(BSL_OFF_CTRL, 32'h1);
    `CHK(resp_q, BSL_RESP_OKAY)
    rd_q = 0;
    while (rd_q[BSL_STAT_DONE] !== 1'b1) rd(BSL_OFF_STATUS);
    `CHK(rd_q[6:4], cyc_e)
    rd(BSL_OFF_PC);
    `CHK(resp_q, BSL_RESP_OKAY)
    `CHK(rd_q[15:0], pc_e)
    rd(BSL_OFF_FLAGS);
    `CHK(rd_q[7:0], flg)
  endtask
  // relative branch: taken goes to target in 2 cycles, else pc+1 in 1
  task automatic br(input logic [15:0] w, input logic [7:0] f, input logic tk,
                    input logic [15:0] tgt);
    run({16'h0, w}, f, 1'b0, tk ? tgt : 16'h11, tk ? 3'h2 : 3'h1);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] f;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    // every flag select, both levels; select 4 is n xor v, s kept low
    for (int s = 0; s < 8; s++) begin
      for (int v = 0; v < 2; v++) begin
        f = (s == 4) ? (v[0] ? 8'h04 : 8'h0C) : (v[0] ? 8'h01 << s : 8'h00);
        br(16'hF028 | s[15:0], f, v[0], 16'h10 + 16'h6);
        br(16'hF7E8 | s[15:0], f, !v[0], 16'h10 - 16'h2);
      end
    end
    $display("branch test done");
    setreg(5'h01, 8'h33);
    setreg(5'h02, 8'h33);
    run(32'h1012, 8'h00, 1'b0, 16'h12, 3'h2);
    run(32'h1012, 8'hFF, 1'b1, 16'h13, 3'h3);
    setreg(5'h02, 8'h34);
    run(32'h1012, 8'h00, 1'b1, 16'h11, 3'h1);
    run(32'hFC13, 8'h00, 1'b1, 16'h13, 3'h3);
    run(32'hFE13, 8'h00, 1'b0, 16'h11, 3'h1);
    run(32'hFE10, 8'h00, 1'b0, 16'h12, 3'h2);
    // bit-transfer word next to the skips: stepped over and reported
    run(32'hFA10, 8'h00, 1'b0, 16'h11, 3'h1);
    rd(BSL_OFF_STATUS);
    `CHK(rd_q[BSL_STAT_ILLEGAL], 1'b1)
    run(32'h992A, 8'h00, 1'b0, 16'h11, 3'h2);
    run(32'h992D, 8'h00, 1'b0, 16'h12, 3'h3);
    run(32'h9B2A, 8'h00, 1'b1, 16'h13, 3'h4);
    $display("skip test done");
    run({16'h0123, 16'h9030}, 8'h00, 1'b0, 16'h12, 3'h2);
    getreg(5'h03);
    `CHK(rd_q[7:0], mem(16'h0123))
    // pointer at 0x01FF so the increment carries into the high byte
    setreg(5'h1A, 8'hFF);
    setreg(5'h1B, 8'h01);
    run(32'h904D, 8'h00, 1'b0, 16'h11, 3'h1);
    getreg(5'h04);
    `CHK(rd_q[7:0], mem(16'h01FF))
    getreg(5'h1B);
    `CHK(rd_q[7:0], 8'h02)
    run(32'h905E, 8'h00, 1'b0, 16'h11, 3'h2);
    getreg(5'h05);
    `CHK(rd_q[7:0], mem(16'h01FF))
    getreg(5'h1A);
    `CHK(rd_q[7:0], 8'hFF)
    // z pair still zero from reset, post-increment into r6
    run(32'h9061, 8'h00, 1'b0, 16'h11, 3'h1);
    getreg(5'h06);
    `CHK(rd_q[7:0], mem(16'h0000))
    getreg(5'h1E);
    `CHK(rd_q[7:0], 8'h01)
    $display("load test done");
    // responses held back two edges so the slave must keep them standing
    rd(8'h20, 2);
    `CHK(resp_q, BSL_RESP_SLVERR)
    `CHK(rd_q, 32'h0)
    wr(8'h24, 32'h1, 2);
    `CHK(resp_q, BSL_RESP_SLVERR)
    $display("map test done");
    give_verdict();
  end
  // about 1,200 cycles of traffic expected; cut off well beyond
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end
endmodule // cpu_branch_skip_load_exec_bench
